// [sim/hves_rail_model.sv]
// behavioural output rail and its comparators behind the pass switch
`timescale 1ns/1ps

module hves_rail_model #(
    parameter int RAMP_CYC = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // pass switch and injected short
    input wire logic main_pass_switch,
    input wire logic short_req,
    // comparator levels
    output logic out_at_in,
    output logic out_below_sc
);
    int level_q;
    // the rail charges only while the switch conducts; a short or open switch drains it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= 0;
        end else if (!main_pass_switch || short_req) begin
            level_q <= 0;
        end else if (level_q < RAMP_CYC) begin
            level_q <= level_q + 1;
        end
    end
    // a larger RAMP_CYC gives a slow rail
    assign out_at_in = level_q >= RAMP_CYC;
    assign out_below_sc = level_q < RAMP_CYC / 2;
endmodule : hves_rail_model

// [sim/hves_sequencer_asserts.sv]
// assertion checker for the high voltage fuse sequencer
`timescale 1ns/1ps

module hves_sequencer_asserts #(
    parameter int UV_DEGLITCH_CYC = 40,
    parameter int UV_RESTART_CYC = 20,
    parameter int BIAS_SETTLE_CYC = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // sense and register port
    input wire hves_pkg::hves_sense_t sense,
    input wire logic [hves_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    // fuse, monitor and interrupt
    input wire logic bias_en,
    input wire logic main_pass_switch,
    input wire hves_pkg::hves_limit_t limit_sel,
    input wire logic mon_en,
    input wire logic mon_gain,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe
);
    // ------------------------------------------------------------
    // run lengths of levels, raw so they lead the synchroniser
    // ------------------------------------------------------------
    int uv_hi;
    int uv_lo;
    int bias_on;
    int atin_lo;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            uv_hi <= 0;
            uv_lo <= 0;
            bias_on <= 0;
            atin_lo <= 0;
        end else begin
            uv_hi <= sense.uv_raw ? uv_hi + 1 : 0;
            uv_lo <= sense.uv_raw ? 0 : uv_lo + 1;
            bias_on <= bias_en ? bias_on + 1 : 0;
            atin_lo <= sense.out_at_in ? 0 : atin_lo + 1;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_pass_on; $rose(main_pass_switch); endsequence
    property p_pass_bias; main_pass_switch |-> bias_en; endproperty
    property p_settle; s_pass_on |-> bias_on >= BIAS_SETTLE_CYC; endproperty
    property p_start_lim; s_pass_on |-> limit_sel == hves_pkg::LIM_STARTUP; endproperty
    property p_off_lim; !main_pass_switch |-> limit_sel == hves_pkg::LIM_STARTUP; endproperty
    property p_restart; s_pass_on |-> uv_lo >= UV_RESTART_CYC; endproperty
    // other shutdown causes are left out, so only a long dip may open the switch
    property p_dip; main_pass_switch && uv_hi < UV_DEGLITCH_CYC && !sense.overtemp
        && !sense.pd_pin && !sense.fw_permit |=> main_pass_switch; endproperty
    property p_oc; (main_pass_switch && limit_sel != hves_pkg::LIM_OPERATIVE) [*2]
        |-> interrupt_out_n_oe; endproperty
    property p_irq; interrupt_out_n_oe |-> !interrupt_out_n_o; endproperty
    property p_mon; $changed({mon_en, mon_gain}) |-> $past(reg_wr) && $past(reg_addr)
        == hves_pkg::ADDR_CONTROL || $past(reg_wr, 2) && $past(reg_addr, 2)
        == hves_pkg::ADDR_CONTROL; endproperty
    property p_short; sense.out_below_sc && limit_sel == hves_pkg::LIM_OPERATIVE
        |-> ##[1:6] limit_sel != hves_pkg::LIM_OPERATIVE; endproperty
    property p_hold; limit_sel == hves_pkg::LIM_SHORT && atin_lo >= 5
        |=> limit_sel != hves_pkg::LIM_OPERATIVE; endproperty

    a_pass_bias: assert property (p_pass_bias)
        else $error("switch on without bias");
    a_settle: assert property (p_settle)
        else $error("ramp before bias settled");
    a_start_lim: assert property (p_start_lim)
        else $error("enable without start-up limit");
    a_off_lim: assert property (p_off_lim)
        else $error("idle fuse lost start-up limit");
    a_restart: assert property (p_restart)
        else $error("restart too early after dip");
    a_dip: assert property (p_dip)
        else $error("short dip opened the switch");
    a_oc: assert property (p_oc)
        else $error("start-up flag not pending");
    a_irq: assert property (p_irq)
        else $error("interrupt pin driven high");
    a_mon: assert property (p_mon)
        else $error("monitor changed without write");
    a_short: assert property (p_short)
        else $error("short limit not selected");
    a_hold: assert property (p_hold)
        else $error("short limit left early");
endmodule : hves_sequencer_asserts

bind hves_sequencer hves_sequencer_asserts #(
    .UV_DEGLITCH_CYC(UV_DEGLITCH_CYC), .UV_RESTART_CYC(UV_RESTART_CYC),
    .BIAS_SETTLE_CYC(BIAS_SETTLE_CYC)
) u_hves_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .sense(sense), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .bias_en(bias_en), .main_pass_switch(main_pass_switch), .limit_sel(limit_sel),
    .mon_en(mon_en), .mon_gain(mon_gain), .interrupt_out_n_o(interrupt_out_n_o),
    .interrupt_out_n_oe(interrupt_out_n_oe)
);

// [sim/tb_top.sv]
// self-checking testbench for the high voltage fuse sequencer
`timescale 1ns/1ps

module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    hves_pkg::hves_sense_t ctl = 9'h01c; // supplies present, input good, cool
    hves_pkg::hves_sense_t sense_w;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic short_req = 1'b0;
    logic [7:0] reg_rdata, rd;
    logic bias_en, main_pass_switch, mon_en, mon_gain, irq_o, irq_oe, irq_pin, at_in, below;
    hves_pkg::hves_limit_t limit_sel;
    int mismatches = 0;
    int checked = 0;

    always #2 sys_clk = ~sys_clk;
    assign sense_w = {ctl[8:2], at_in, below};
    assign irq_pin = irq_oe ? irq_o : 1'b1; // pulled up when released

    hves_sequencer #(.UV_DEGLITCH_CYC(40), .UV_RESTART_CYC(20), .BIAS_SETTLE_CYC(10)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .sense(sense_w), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bias_en(bias_en), .main_pass_switch(main_pass_switch), .limit_sel(limit_sel),
        .mon_en(mon_en), .mon_gain(mon_gain), .interrupt_out_n_o(irq_o),
        .interrupt_out_n_oe(irq_oe)
    );
    hves_rail_model #(.RAMP_CYC(8)) rail (
        .sys_clk(sys_clk), .arst_n(arst_n), .main_pass_switch(main_pass_switch),
        .short_req(short_req), .out_at_in(at_in), .out_below_sc(below)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic check_lim(input hves_pkg::hves_limit_t exp);
        check({6'h00, limit_sel}, {6'h00, exp});
    endtask : check_lim
    task automatic check_pass(input logic lvl);
        check({7'h00, main_pass_switch}, {7'h00, lvl});
    endtask : check_pass
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // bounded wait for the switch to reach a level
    task automatic wait_pass(input logic lvl, input int lim);
        for (int i = 0; i < lim && main_pass_switch !== lvl; i++) @(posedge sys_clk);
    endtask : wait_pass
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : reg_read
    task automatic stop_test;
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs;
        reg_read(hves_pkg::ADDR_CONTROL, rd);
        check(rd, hves_pkg::CONTROL_RST); // control
        check({6'h00, mon_gain, mon_en}, 8'h00); // monitor
        reg_read(8'h7e, rd);
        check(rd, 8'h00); // unmapped
    endtask : t_reset_regs
    task automatic t_startup;
        wait_pass(1'b1, 60);
        check_pass(1'b1); // good input
        check_lim(hves_pkg::LIM_STARTUP); // limit
        reg_write(hves_pkg::ADDR_STATUS, 8'h0f);
        reg_read(hves_pkg::ADDR_STATUS, rd);
        check({7'h00, rd[hves_pkg::ST_OC_BIT]}, 8'h01); // flag
        check({7'h00, irq_pin}, 8'h00); // pin low
        // host polls and clears until the ramp flag stays away
        for (int i = 0; i < 20 && rd[hves_pkg::ST_OC_BIT] !== 1'b0; i++) begin
            reg_write(hves_pkg::ADDR_STATUS, 8'h0f);
            reg_read(hves_pkg::ADDR_STATUS, rd);
        end
        check(rd, 8'h00); // flags clear
        check_lim(hves_pkg::LIM_OPERATIVE); // limit
        check({7'h00, irq_pin}, 8'h01); // released
    endtask : t_startup
    task automatic t_short;
        short_req <= 1'b1;
        cyc(10);
        check_lim(hves_pkg::LIM_SHORT); // limit
        check({7'h00, irq_pin}, 8'h00); // pending
        short_req <= 1'b0;
        cyc(6);
        check_lim(hves_pkg::LIM_SHORT); // still reduced
        cyc(10);
        check_lim(hves_pkg::LIM_OPERATIVE); // recovered
        reg_write(hves_pkg::ADDR_STATUS, 8'h0f);
    endtask : t_short
    task automatic t_uv;
        ctl.uv_raw <= 1'b1;
        cyc(30);
        ctl.uv_raw <= 1'b0;
        cyc(3);
        ctl.uv_raw <= 1'b1;
        cyc(30);
        ctl.uv_raw <= 1'b0;
        cyc(6);
        check_pass(1'b1); // dips filtered
        ctl.uv_raw <= 1'b1;
        wait_pass(1'b0, 60);
        check_pass(1'b0); // long dip
        ctl.uv_raw <= 1'b0;
        cyc(12);
        ctl.uv_raw <= 1'b1;
        cyc(3);
        ctl.uv_raw <= 1'b0;
        cyc(16);
        check({7'h00, bias_en}, 8'h00); // delay restarted
        wait_pass(1'b1, 60);
        check_pass(1'b1); // restart
        check_lim(hves_pkg::LIM_STARTUP); // limit
        cyc(20);
        reg_write(hves_pkg::ADDR_STATUS, 8'h0f);
    endtask : t_uv
    task automatic t_thermal;
        ctl.overtemp <= 1'b1;
        cyc(8);
        check_pass(1'b0); // shut
        ctl.pd_pin <= 1'b1;
        cyc(6);
        ctl.pd_pin <= 1'b0;
        cyc(6);
        ctl.overtemp <= 1'b0;
        cyc(60);
        check_pass(1'b0); // latched
        ctl.other_supply <= 1'b0;
        ctl.internal_analog_supply_ok <= 1'b0;
        ctl.pd_pin <= 1'b1;
        cyc(6);
        ctl.pd_pin <= 1'b0;
        cyc(40);
        check({7'h00, bias_en}, 8'h00); // awaits supply
        ctl.internal_analog_supply_ok <= 1'b1;
        wait_pass(1'b1, 40);
        check_pass(1'b1); // restart
        check_lim(hves_pkg::LIM_STARTUP); // limit
        ctl.other_supply <= 1'b1;
        cyc(20);
        reg_write(hves_pkg::ADDR_STATUS, 8'h0f);
    endtask : t_thermal
    task automatic t_pd_fw;
        reg_write(hves_pkg::ADDR_CONTROL, 8'h07);
        cyc(2);
        check({6'h00, mon_gain, mon_en}, 8'h03); // monitor
        ctl.pd_pin <= 1'b1;
        wait_pass(1'b0, 12);
        check_pass(1'b0); // disabled
        ctl.pd_pin <= 1'b0;
        wait_pass(1'b1, 40);
        check_pass(1'b1); // released
        reg_write(hves_pkg::ADDR_CONTROL, 8'h09);
        cyc(10);
        check({6'h00, mon_gain, mon_en}, 8'h01); // gain
        check_pass(1'b1); // no permit
        ctl.fw_permit <= 1'b1;
        wait_pass(1'b0, 12);
        check_pass(1'b0); // permitted
        reg_write(hves_pkg::ADDR_CONTROL, 8'h00);
        cyc(2);
        check({6'h00, mon_gain, mon_en}, 8'h00); // off
    endtask : t_pd_fw

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset_regs();
        t_startup();
        t_short();
        t_uv();
        t_thermal();
        t_pd_fw();
        stop_test();
    end
    // the tests need at most about 700 cycles; 25000 leaves ample margin
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
endmodule : tb_top

// [verilog/hves_pkg.sv]
// shared constants and types for the high voltage fuse sequencer
package hves_pkg;

    // --------------------
    // timebase
    // --------------------
    localparam int CLK_MHZ = 250; // sys_clk rate
    localparam int UV_DEGLITCH_US = 500; // input dip must last longer than this
    localparam int UV_RESTART_US = 200; // input must stay good this long
    localparam int BIAS_SETTLE_US = 100; // bias on to start of ramp
    localparam int UV_DEGLITCH_CYC = UV_DEGLITCH_US * CLK_MHZ;
    localparam int UV_RESTART_CYC = UV_RESTART_US * CLK_MHZ;
    localparam int BIAS_SETTLE_CYC = BIAS_SETTLE_US * CLK_MHZ;
    localparam int CNT_W = 17; // holds the largest count above

    // --------------------
    // register port and map
    // --------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00; // first_status_register
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h01; // first_control_register
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
    localparam logic [DATA_W-1:0] CONTROL_RST = 8'h00;

    // status bits, write one to clear
    localparam int ST_OC_BIT = 0; // hv_overcurrent_flag
    localparam int ST_UV_BIT = 1; // undervoltage shutdown happened
    localparam int ST_OT_BIT = 2; // thermal latch-off happened
    localparam int ST_PD_BIT = 3; // power-disable shut the fuse
    localparam int ST_USED = 4;

    // control bits
    localparam int CT_MON_EN_BIT = 0; // current monitor on
    localparam int CT_MON_GAIN_BIT = 1; // current monitor gain select
    localparam int CT_PD_EN_BIT = 2; // power_disable_enable_bit
    localparam int CT_FW_OFF_BIT = 3; // firmware disable request
    localparam int CT_USED = 4;

    // --------------------
    // types
    // --------------------
    typedef enum logic [1:0] {
        LIM_STARTUP,
        LIM_OPERATIVE,
        LIM_SHORT
    } hves_limit_t;

    // analogue and pin levels, all asynchronous to sys_clk
    typedef struct packed {
        logic uv_raw; // hv_input_undervoltage_level, high = input too low
        logic overtemp; // hv_overtemp_level, high = too hot
        logic pd_pin; // power_disable_pin level
        logic fw_permit; // firmware_disable_permit_pin level
        logic other_supply; // chip already powered from another input
        logic internal_analog_supply_ok; // internal_analog_supply has reached 1.8 V
        logic lv_good; // low_voltage_input_rail present
        logic out_at_in; // hv_output_rail has reached hv_input_rail
        logic out_below_sc; // hv_output_rail below 7.5 V
    } hves_sense_t;

endpackage : hves_pkg

// [verilog/hves_sequencer.sv]
// digital sequencer for the 12 V electronic fuse
`timescale 1ns/1ps

module hves_sequencer #(
    parameter int UV_DEGLITCH_CYC = hves_pkg::UV_DEGLITCH_CYC,
    parameter int UV_RESTART_CYC = hves_pkg::UV_RESTART_CYC,
    parameter int BIAS_SETTLE_CYC = hves_pkg::BIAS_SETTLE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // analogue comparators and pins
    input wire hves_pkg::hves_sense_t sense,
    // register port
    input wire logic [hves_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hves_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hves_pkg::DATA_W-1:0] reg_rdata,
    // pass switch and current limit
    output logic bias_en,
    output logic main_pass_switch,
    output hves_pkg::hves_limit_t limit_sel,
    // current monitor
    output logic mon_en,
    output logic mon_gain,
    // open-drain interrupt_out_n
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe
);

    // --------------------
    // helpers
    // --------------------

    // counter step that stops at its top value
    function automatic logic [hves_pkg::CNT_W-1:0] sat_inc(
        input logic [hves_pkg::CNT_W-1:0] v,
        input logic [hves_pkg::CNT_W-1:0] top
    );
        sat_inc = (v >= top) ? top : v + 1'b1;
    endfunction : sat_inc

    localparam logic [hves_pkg::CNT_W-1:0] DEGL_TOP = UV_DEGLITCH_CYC[hves_pkg::CNT_W-1:0];
    localparam logic [hves_pkg::CNT_W-1:0] RSTR_TOP = UV_RESTART_CYC[hves_pkg::CNT_W-1:0];
    localparam logic [hves_pkg::CNT_W-1:0] BIAS_TOP = BIAS_SETTLE_CYC[hves_pkg::CNT_W-1:0];
    localparam logic [hves_pkg::CNT_W-1:0] CNT_ZERO = 17'h00000;

    typedef enum logic [2:0] {
        S_OFF,
        S_SUPPLY,
        S_BIAS,
        S_RAMP,
        S_RUN,
        S_SHORT
    } hves_state_t;

    // --------------------
    // input synchronisers
    // --------------------

    // three stages; a level is taken only once stages two and three agree,
    // which rejects a single metastable sample at the cost of one cycle
    hves_pkg::hves_sense_t sync1_q;
    hves_pkg::hves_sense_t sync2_q;
    hves_pkg::hves_sense_t sync3_q;
    hves_pkg::hves_sense_t filt_q;
    hves_pkg::hves_sense_t filt_d;
    wire hves_pkg::hves_sense_t agree = ~(sync2_q ^ sync3_q);

    assign filt_d = (sync2_q & agree) | (filt_q & ~agree);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q <= '0;
        end else begin
            sync1_q <= sense;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= filt_d;
        end
    end

    // previous filtered levels for edge detection
    logic pd_pin_prev_q;
    logic lv_good_prev_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pd_pin_prev_q <= 1'b0;
            lv_good_prev_q <= 1'b0;
        end else begin
            pd_pin_prev_q <= filt_q.pd_pin;
            lv_good_prev_q <= filt_q.lv_good;
        end
    end

    wire pd_toggle = filt_q.pd_pin ^ pd_pin_prev_q;
    wire lv_powerup = filt_q.lv_good & ~lv_good_prev_q;

    // --------------------
    // undervoltage deglitch and restart delay
    // --------------------
    logic [hves_pkg::CNT_W-1:0] degl_cnt_q;
    logic [hves_pkg::CNT_W-1:0] degl_cnt_d;
    logic [hves_pkg::CNT_W-1:0] rstr_cnt_q;
    logic [hves_pkg::CNT_W-1:0] rstr_cnt_d;
    logic uv_shut_q;
    logic uv_shut_d;

    // dip counter clears once the comparator reads good
    assign degl_cnt_d = filt_q.uv_raw ? sat_inc(degl_cnt_q, DEGL_TOP) : CNT_ZERO;
    // restart timer runs while shut and good; a dip restarts it
    assign rstr_cnt_d = (uv_shut_q && !filt_q.uv_raw) ? sat_inc(rstr_cnt_q, RSTR_TOP)
        : CNT_ZERO;
    wire uv_trip = filt_q.uv_raw && (degl_cnt_q >= DEGL_TOP);
    wire uv_recover = uv_shut_q && !filt_q.uv_raw && (rstr_cnt_q >= RSTR_TOP);
    assign uv_shut_d = uv_trip ? 1'b1 : (uv_recover ? 1'b0 : uv_shut_q);

    // shut starts set: input not yet seen good long enough
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            degl_cnt_q <= CNT_ZERO;
            rstr_cnt_q <= CNT_ZERO;
            uv_shut_q <= 1'b1;
        end else begin
            degl_cnt_q <= degl_cnt_d;
            rstr_cnt_q <= rstr_cnt_d;
            uv_shut_q <= uv_shut_d;
        end
    end

    // --------------------
    // thermal latch
    // --------------------
    logic ot_latch_q;
    logic ot_latch_d;

    // a hv input power-up is the end of an undervoltage shutdown
    wire supply_cycle = uv_recover | lv_powerup;
    wire ot_release = !filt_q.overtemp && (pd_toggle || supply_cycle);
    // set wins, and the latch never clears on cooling alone
    assign ot_latch_d = filt_q.overtemp ? 1'b1 : (ot_release ? 1'b0 : ot_latch_q);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ot_latch_q <= 1'b0;
        end else begin
            ot_latch_q <= ot_latch_d;
        end
    end

    // --------------------
    // register port decode
    // --------------------
    logic [hves_pkg::DATA_W-1:0] status_q;
    logic [hves_pkg::DATA_W-1:0] status_d;
    logic [hves_pkg::DATA_W-1:0] control_q;
    logic [hves_pkg::DATA_W-1:0] control_d;
    logic [hves_pkg::DATA_W-1:0] rdata_q;
    logic [hves_pkg::DATA_W-1:0] rdata_d;

    wire wr_status = reg_wr && (reg_addr == hves_pkg::ADDR_STATUS);
    wire wr_control = reg_wr && (reg_addr == hves_pkg::ADDR_CONTROL);
    wire rd_status = reg_rd && (reg_addr == hves_pkg::ADDR_STATUS);
    wire rd_control = reg_rd && (reg_addr == hves_pkg::ADDR_CONTROL);

    // --------------------
    // power-disable
    // --------------------

    // the pin acts when its enable bit is set; firmware may add its own off
    // request only while the permit input is high
    wire pd_by_pin = filt_q.pd_pin && control_q[hves_pkg::CT_PD_EN_BIT];
    wire pd_by_fw = filt_q.fw_permit && control_q[hves_pkg::CT_FW_OFF_BIT];
    wire pd_active = pd_by_pin || pd_by_fw;

    // fuse may run only with the filtered input good, cool and not disabled
    wire run_ok = !uv_shut_q && !ot_latch_q && !pd_active;

    // --------------------
    // start-up sequencer
    // --------------------
    hves_state_t state_q;
    hves_state_t state_d;
    logic [hves_pkg::CNT_W-1:0] bias_cnt_q;
    logic [hves_pkg::CNT_W-1:0] bias_cnt_d;

    // losing run_ok from any state drops to off, so every restart passes
    // through the ramp with the start-up limit
    always_comb begin
        state_d = state_q;
        if (!run_ok) begin
            state_d = S_OFF;
        end else begin
            case (state_q)
                S_OFF: begin
                    state_d = filt_q.other_supply ? S_BIAS : S_SUPPLY;
                end
                S_SUPPLY: begin
                    if (filt_q.internal_analog_supply_ok || filt_q.other_supply) begin
                        state_d = S_BIAS;
                    end
                end
                S_BIAS: begin
                    if (bias_cnt_q >= BIAS_TOP) begin
                        state_d = S_RAMP;
                    end
                end
                S_RAMP: begin
                    if (filt_q.out_at_in) begin
                        state_d = S_RUN;
                    end
                end
                S_RUN: begin
                    if (filt_q.out_below_sc) begin
                        state_d = S_SHORT;
                    end
                end
                S_SHORT: begin
                    if (filt_q.out_at_in) begin
                        state_d = S_RUN;
                    end
                end
                default: begin
                    state_d = S_OFF;
                end
            endcase
        end
    end

    // bias settle timer counts only in the bias state
    assign bias_cnt_d = (state_q == S_BIAS) ? sat_inc(bias_cnt_q, BIAS_TOP) : CNT_ZERO;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_OFF;
            bias_cnt_q <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            bias_cnt_q <= bias_cnt_d;
        end
    end

    // --------------------
    // outputs toward the pass switch
    // --------------------
    logic bias_q;
    logic switch_q;
    hves_pkg::hves_limit_t limit_q;
    hves_pkg::hves_limit_t limit_d;

    wire bias_d = (state_d == S_BIAS) || (state_d == S_RAMP) ||
                  (state_d == S_RUN) || (state_d == S_SHORT);
    wire switch_d = (state_d == S_RAMP) || (state_d == S_RUN) || (state_d == S_SHORT);

    // start-up limit is the default, so off and bias states already hold it
    assign limit_d = (state_d == S_RUN) ? hves_pkg::LIM_OPERATIVE :
        (state_d == S_SHORT) ? hves_pkg::LIM_SHORT :
        hves_pkg::LIM_STARTUP;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bias_q <= 1'b0;
            switch_q <= 1'b0;
            limit_q <= hves_pkg::LIM_STARTUP;
        end else begin
            bias_q <= bias_d;
            switch_q <= switch_d;
            limit_q <= limit_d;
        end
    end

    // --------------------
    // status register
    // --------------------

    // the ramp is the start-up limiting phase
    wire startup_limiting = (state_q == S_RAMP);

    logic [hves_pkg::DATA_W-1:0] status_set;
    logic [hves_pkg::DATA_W-1:0] status_clr;

    always_comb begin
        status_set = '0;
        status_set[hves_pkg::ST_OC_BIT] = startup_limiting || (state_q == S_SHORT);
        status_set[hves_pkg::ST_UV_BIT] = uv_trip && !uv_shut_q;
        status_set[hves_pkg::ST_OT_BIT] = filt_q.overtemp && !ot_latch_q;
        status_set[hves_pkg::ST_PD_BIT] = pd_active && switch_q;
    end

    // write one to clear; a same-cycle set wins
    assign status_clr = wr_status ? reg_wdata : '0;
    assign status_d = ((status_q & ~status_clr) | status_set) &
                      {{(hves_pkg::DATA_W-hves_pkg::ST_USED){1'b0}}, {hves_pkg::ST_USED{1'b1}}};

    // --------------------
    // control register
    // --------------------

    // monitor stays off from reset until software writes the enable
    assign control_d = wr_control ?
        (reg_wdata & {{(hves_pkg::DATA_W-hves_pkg::CT_USED){1'b0}}, {hves_pkg::CT_USED{1'b1}}})
        : control_q;

    // read data for the cycle after the strobe; unmapped reads give zero
    assign rdata_d = rd_status ? status_q :
                     rd_control ? control_q : '0;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= hves_pkg::STATUS_RST;
            control_q <= hves_pkg::CONTROL_RST;
            rdata_q <= '0;
        end else begin
            status_q <= status_d;
            control_q <= control_d;
            rdata_q <= rdata_d;
        end
    end

    // --------------------
    // monitor and interrupt outputs
    // --------------------
    logic mon_en_q;
    logic mon_gain_q;
    logic irq_oe_q;
    logic irq_o_q;

    // monitor bits are shared with the other fuse, so they are plain copies
    // of the register and not gated by this fuse's state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_en_q <= 1'b0;
            mon_gain_q <= 1'b0;
            irq_oe_q <= 1'b0;
            irq_o_q <= 1'b0;
        end else begin
            mon_en_q <= control_d[hves_pkg::CT_MON_EN_BIT];
            mon_gain_q <= control_d[hves_pkg::CT_MON_GAIN_BIT];
            irq_oe_q <= |status_d;
            irq_o_q <= 1'b0; // open drain only pulls low
        end
    end

    assign reg_rdata = rdata_q;
    assign bias_en = bias_q;
    assign main_pass_switch = switch_q;
    assign limit_sel = limit_q;
    assign mon_en = mon_en_q;
    assign mon_gain = mon_gain_q;
    assign interrupt_out_n_o = irq_o_q;
    assign interrupt_out_n_oe = irq_oe_q;

endmodule : hves_sequencer
